//--- logic/dmb_pkg.sv
// Overview of operation
// RULE1 - Remap bits 31:16 replace decoded address bits
// RULE2 - Memory window decodes only when bit0 set
// RULE3 - I/O window decodes only when bit1 set
// RULE4 - Software should set lock-input enable bit2
// RULE5 - Bit4 picks release-bus or withhold-IRDY on full
// RULE6 - Software keeps almost-full bits 7:5 cleared
// RULE7 - Memory base holds 31:16; low half reads zero
// RULE8 - I/O-config base holds 31:16; low half zero
// RULE9 - Config address fields: type, reg, fn, dev, bus
// RULE10 - Bit31 turns I/O-window accesses into config cycles
// RULE11 - Detect inbound request during outbound access deadlock
// RULE12 - Assert back-off on deadlock when processor supports it
// RULE13 - Otherwise force false ready to end cycle
// RULE14 - Forced termination raises fatal deadlock interrupt
// RULE15 - Count clocks; at time-out assert bus-request-out
// RULE16 - Software programs time-out and enable first
// RULE17 - Retry PCI master accesses until init done
// RULE18 - Local code sets init-status bit last
// RULE19 - Range bits 31:16 select decoded address bits
// RULE20 - Hit replaces decoded bits with remap bits
// RULE21 - Hit when masked address equals masked base
package dmb_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] DMB_OFF_DLCTL  = 8'h94;
    localparam logic [7:0] DMB_OFF_RANGE  = 8'h9c;
    localparam logic [7:0] DMB_OFF_MBASE  = 8'ha0;
    localparam logic [7:0] DMB_OFF_IOBASE = 8'ha4;
    localparam logic [7:0] DMB_OFF_REMAP  = 8'ha8;
    localparam logic [7:0] DMB_OFF_CFGADR = 8'hac;
    localparam logic [7:0] DMB_OFF_INIT   = 8'hec;
    localparam logic [7:0] DMB_OFF_STAT   = 8'hf0;

    // ------------------------------------------------------------
    // Field positions and masks
    // ------------------------------------------------------------
    localparam int          DMB_REMAP_MEM_EN   = 0;
    localparam int          DMB_REMAP_IO_EN    = 1;
    localparam int          DMB_REMAP_LOCK_EN  = 2;
    localparam int          DMB_REMAP_PREFETCH = 3;
    localparam int          DMB_REMAP_RDMODE   = 4;
    localparam int          DMB_REMAP_PAF_LO   = 5;
    localparam int          DMB_REMAP_PAF_HI   = 7;
    localparam logic [31:0] DMB_REMAP_WMASK    = 32'hffff_00ff;
    localparam logic [31:0] DMB_HI_MASK        = 32'hffff_0000;
    localparam int          DMB_DL_TMO_HI      = 3;
    localparam int          DMB_DL_BREQ_EN     = 4;
    localparam logic [31:0] DMB_DL_WMASK       = 32'h0000_001f;
    localparam int          DMB_CFG_EN         = 31;
    localparam int          DMB_INIT_DONE      = 31;
    localparam logic [31:0] DMB_INIT_WMASK     = 32'h8000_0000;
    localparam int          DMB_STAT_DLERR     = 0;
    localparam int          DMB_STAT_DLPEND    = 1;
    localparam int          DMB_STAT_BREQ      = 2;
    localparam int          DMB_STAT_INBOUND   = 3;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [31:0] DMB_RST_ZERO = 32'h0000_0000;
    localparam logic [3:0]  DMB_CNT_ZERO = 4'h0;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        DMB_SP_MEM = 2'h0,
        DMB_SP_IO  = 2'h1,
        DMB_SP_CFG = 2'h2
    } dmb_space_e;

    typedef enum logic [2:0]
    {
        DMB_DL_IDLE   = 3'b001,
        DMB_DL_COUNT  = 3'b010,
        DMB_DL_ASSERT = 3'b100
    } dmb_dl_state_e;

    typedef struct packed
    {
        logic        valid;
        dmb_space_e  space;
        logic [31:0] addr;
    } dmb_pci_req_s;

    typedef struct packed
    {
        logic        req;
        logic        io;
        logic [31:0] addr;
    } dmb_lcl_req_s;

endpackage

//--- logic/dmb_sync.sv
`timescale 1ns/1ps
`default_nettype none
module dmb_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    // ------------------------------------------------------------
    // Two-stage synchroniser; first stage feeds only the second
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            meta_q   <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

//--- logic/dmb_bridge.sv
`timescale 1ns/1ps
`default_nettype none
module dmb_bridge (
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire dmb_pkg::dmb_lcl_req_s lcl_req,
    output dmb_pkg::dmb_pci_req_s      pci_req,
    input  wire logic                  pci_clk,
    input  wire logic                  pci_inbound_req,
    input  wire logic                  pci_tgt_access,
    input  wire logic                  cpu_has_backoff,
    input  wire logic [3:0]            wfifo_count,
    output logic                       pci_tgt_retry,
    output logic                       bus_request_out,
    output logic                       backoff,
    output logic                       false_ready,
    output logic                       deadlock_error_interrupt,
    output logic                       pci_lock_en,
    output logic                       rd_full_keep_bus,
    output logic                       write_fifo_almost_full_flag_n
);
    import dmb_pkg::*;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [31:0]   dlctl_q;
    logic [31:0]   range_q;
    logic [31:0]   mbase_q;
    logic [31:0]   iobase_q;
    logic [31:0]   remap_q;
    logic [31:0]   cfgadr_q;
    logic [31:0]   init_q;
    logic          dlerr_q;
    logic [31:0]   prdata_q;
    logic          pready_q;
    logic          pslverr_q;
    logic [31:0]   rdata_d;
    logic          mapped_d;
    logic          wr_en;
    logic          rd_en;

    // ------------------------------------------------------------
    // Synchronised pins (PCI clock sampled like any pin)
    // ------------------------------------------------------------
    logic [3:0]    sync_s;
    logic          pclk_s;
    logic          pclk_prev_q;
    logic          inbound_q;
    logic          tgt_s;
    logic          backoff_cap_s;

    dmb_sync #(
        .W(4)
    ) u_sync (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .async_in ({pci_clk, pci_inbound_req, pci_tgt_access, cpu_has_backoff}),
        .sync_out (sync_s)
    );

    assign pclk_s        = sync_s[3];
    assign tgt_s         = sync_s[1];
    assign backoff_cap_s = sync_s[0];

    // ------------------------------------------------------------
    // Window decode and address remap
    // ------------------------------------------------------------
    logic          mem_hit;
    logic          io_hit;
    logic [31:0]   pci_addr_d;
    logic [31:0]   cfg_addr_d;

    // Only the upper half takes part; range low bits are always zero
    assign mem_hit = remap_q[DMB_REMAP_MEM_EN] && !lcl_req.io     // RULE2
        && ((lcl_req.addr & range_q) == (mbase_q & range_q));     // RULE21 RULE19
    assign io_hit  = remap_q[DMB_REMAP_IO_EN] && lcl_req.io       // RULE3
        && ((lcl_req.addr & range_q) == (iobase_q & range_q));    // RULE21 RULE8
    assign pci_addr_d = (lcl_req.addr & ~range_q)
        | (remap_q & range_q & DMB_HI_MASK);                      // RULE20 RULE1
    // Config cycles carry the programmed fields, enable bit stripped
    assign cfg_addr_d = {1'b0, cfgadr_q[30:0]};                   // RULE9

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            pci_req <= '{valid: 1'b0, space: DMB_SP_MEM, addr: DMB_RST_ZERO};
        end
        else
        begin
            pci_req.valid <= lcl_req.req && (mem_hit || io_hit);
            if (io_hit && cfgadr_q[DMB_CFG_EN])
            begin
                pci_req.space <= DMB_SP_CFG;                      // RULE10
                pci_req.addr  <= cfg_addr_d;
            end
            else if (io_hit)
            begin
                pci_req.space <= DMB_SP_IO;                       // RULE10
                pci_req.addr  <= pci_addr_d;
            end
            else
            begin
                pci_req.space <= DMB_SP_MEM;
                pci_req.addr  <= pci_addr_d;
            end
        end
    end

    // ------------------------------------------------------------
    // Mode outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            pci_lock_en                   <= 1'b0;
            rd_full_keep_bus              <= 1'b0;
            write_fifo_almost_full_flag_n <= 1'b1;
        end
        else
        begin
            pci_lock_en      <= remap_q[DMB_REMAP_LOCK_EN];       // RULE4
            rd_full_keep_bus <= remap_q[DMB_REMAP_RDMODE];        // RULE5
            // Unused on this platform; kept for completeness
            write_fifo_almost_full_flag_n <=
                !(wfifo_count > {1'b0, remap_q[DMB_REMAP_PAF_HI:DMB_REMAP_PAF_LO]});
        end
    end

    // ------------------------------------------------------------
    // Inbound request sampled on PCI clock rising edges
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            pclk_prev_q <= 1'b0;
            inbound_q   <= 1'b0;
        end
        else
        begin
            pclk_prev_q <= pclk_s;
            if (pclk_s && !pclk_prev_q)
            begin
                inbound_q <= sync_s[2];
            end
        end
    end

    // ------------------------------------------------------------
    // Init-done gate on PCI master accesses
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            pci_tgt_retry <= 1'b0;
        end
        else
        begin
            pci_tgt_retry <= tgt_s && !init_q[DMB_INIT_DONE];     // RULE17
        end
    end

    // ------------------------------------------------------------
    // Deadlock detection and resolution
    // ------------------------------------------------------------
    dmb_dl_state_e dl_q;
    logic [3:0]    dl_cnt_q;
    logic          dl_pend;
    logic          tmo_hit;
    logic          forced_end;

    // Outbound access stalled while an inbound master wants us
    assign dl_pend = inbound_q && lcl_req.req && (mem_hit || io_hit);   // RULE11
    assign tmo_hit = (dl_cnt_q == dlctl_q[DMB_DL_TMO_HI:0])
        && dlctl_q[DMB_DL_BREQ_EN];                                     // RULE15 RULE16
    // Without back-off the cycle is ended by a false ready
    assign forced_end = (dl_q == DMB_DL_ASSERT) && !backoff_cap_s;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            dl_q     <= DMB_DL_IDLE;
            dl_cnt_q <= DMB_CNT_ZERO;
        end
        else
        begin
            unique case (dl_q)
                DMB_DL_IDLE:
                begin
                    dl_cnt_q <= DMB_CNT_ZERO;
                    if (dl_pend)
                    begin
                        dl_q <= DMB_DL_COUNT;
                    end
                end
                DMB_DL_COUNT:
                begin
                    if (!dl_pend)
                    begin
                        dl_q <= DMB_DL_IDLE;
                    end
                    else if (tmo_hit)
                    begin
                        dl_q <= DMB_DL_ASSERT;                    // RULE15
                    end
                    else
                    begin
                        dl_cnt_q <= dl_cnt_q + 4'h1;              // RULE15
                    end
                end
                DMB_DL_ASSERT:
                begin
                    if (!dl_pend)
                    begin
                        dl_q <= DMB_DL_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            bus_request_out <= 1'b0;
            backoff         <= 1'b0;
            false_ready     <= 1'b0;
        end
        else
        begin
            bus_request_out <= (dl_q == DMB_DL_ASSERT) && dl_pend;              // RULE15
            backoff         <= (dl_q == DMB_DL_ASSERT) && dl_pend
                && backoff_cap_s;                                               // RULE12
            // One-cycle pulses on every other cycle while the stall lasts, to end the stalled cycle
            false_ready     <= forced_end && dl_pend && !false_ready;           // RULE13
        end
    end

    // Sticky fatal flag; a new event beats a same-cycle clear
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            dlerr_q                  <= 1'b0;
            deadlock_error_interrupt <= 1'b0;
        end
        else
        begin
            if (false_ready)
            begin
                dlerr_q <= 1'b1;                                  // RULE14
            end
            else if (wr_en && paddr == DMB_OFF_STAT && pwdata[DMB_STAT_DLERR])
            begin
                dlerr_q <= 1'b0;
            end
            deadlock_error_interrupt <= dlerr_q;                  // RULE14
        end
    end

    // ------------------------------------------------------------
    // APB slave: one wait state, error on unmapped offsets
    // ------------------------------------------------------------
    assign wr_en = psel && penable && pwrite && pready_q;
    assign rd_en = psel && penable && !pwrite && !pready_q;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            dlctl_q  <= DMB_RST_ZERO;
            range_q  <= DMB_RST_ZERO;
            mbase_q  <= DMB_RST_ZERO;
            iobase_q <= DMB_RST_ZERO;
            remap_q  <= DMB_RST_ZERO;
            cfgadr_q <= DMB_RST_ZERO;
            init_q   <= DMB_RST_ZERO;
        end
        else if (wr_en)
        begin
            unique case (paddr)
                DMB_OFF_DLCTL:  dlctl_q  <= pwdata & DMB_DL_WMASK;
                DMB_OFF_RANGE:  range_q  <= pwdata & DMB_HI_MASK;     // RULE19
                DMB_OFF_MBASE:  mbase_q  <= pwdata & DMB_HI_MASK;     // RULE7
                DMB_OFF_IOBASE: iobase_q <= pwdata & DMB_HI_MASK;     // RULE8
                DMB_OFF_REMAP:  remap_q  <= pwdata & DMB_REMAP_WMASK; // RULE1
                DMB_OFF_CFGADR: cfgadr_q <= pwdata;                   // RULE9
                DMB_OFF_INIT:   init_q   <= pwdata & DMB_INIT_WMASK;
                default:        init_q   <= init_q;
            endcase
        end
    end

    always_comb
    begin
        rdata_d  = DMB_RST_ZERO;
        mapped_d = 1'b1;
        unique case (paddr)
            DMB_OFF_DLCTL:  rdata_d = dlctl_q;
            DMB_OFF_RANGE:  rdata_d = range_q;
            DMB_OFF_MBASE:  rdata_d = mbase_q;
            DMB_OFF_IOBASE: rdata_d = iobase_q;
            DMB_OFF_REMAP:  rdata_d = remap_q;
            DMB_OFF_CFGADR: rdata_d = cfgadr_q;
            DMB_OFF_INIT:   rdata_d = init_q;
            DMB_OFF_STAT:
            begin
                rdata_d[DMB_STAT_DLERR]   = dlerr_q;
                rdata_d[DMB_STAT_DLPEND]  = dl_pend;
                rdata_d[DMB_STAT_BREQ]    = bus_request_out;
                rdata_d[DMB_STAT_INBOUND] = inbound_q;
            end
            default:        mapped_d = 1'b0;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= DMB_RST_ZERO;
        end
        else
        begin
            pready_q  <= psel && penable && !pready_q;
            pslverr_q <= psel && penable && !pready_q && !mapped_d;
            if (rd_en)
            begin
                prdata_q <= rdata_d;
            end
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;
endmodule
`default_nettype wire

//--- verif/dmb_pci_agent.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Far-side PCI agent
// ----------------------------------------
module dmb_pci_agent (
    input  wire logic want_inbound,
    input  wire logic want_access,
    output var logic  pci_clk,
    output var logic  pci_inbound_req,
    output var logic  pci_tgt_access
);
    // PCI clock runs free; requests move mid-period, away from the
    // rising edge at which the bridge samples pci_inbound_req
    initial
    begin
        pci_clk = 1'b0;
        pci_inbound_req = 1'b0;
        pci_tgt_access = 1'b0;
    end
    always #62.5 pci_clk = ~pci_clk;
    always @(negedge pci_clk)
    begin
        pci_inbound_req <= want_inbound;
        pci_tgt_access <= want_access;
    end
endmodule
`default_nettype wire

//--- verif/dmb_bridge_properties.sv
`timescale 1ns/1ps
`default_nettype none
module dmb_bridge_properties (
    input wire logic                  clk,
    input wire logic                  sys_rst,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pready,
    input wire logic                  pslverr,
    input wire dmb_pkg::dmb_lcl_req_s lcl_req,
    input wire dmb_pkg::dmb_pci_req_s pci_req,
    input wire logic                  pci_tgt_access,
    input wire logic                  pci_tgt_retry,
    input wire logic                  bus_request_out,
    input wire logic                  backoff,
    input wire logic                  false_ready,
    input wire logic                  deadlock_error_interrupt
);
    import dmb_pkg::*;
    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_pready_wait: assert property (psel && $rose(penable) |=> pready)
        else $error("pready missing after one wait state");
    a_pready_one: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_slverr_rdy: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_req_follow: assert property (pci_req.valid |-> $past(lcl_req.req))
        else $error("pci request without local request");
    a_space_kind: assert property (pci_req.valid |->
        ((pci_req.space == DMB_SP_MEM) == !$past(lcl_req.io)))
        else $error("pci space does not match window");
    a_low_pass: assert property (pci_req.valid && pci_req.space != DMB_SP_CFG |->
        pci_req.addr[15:0] == $past(lcl_req.addr[15:0]))
        else $error("undecoded address bits altered");
    a_backoff_breq: assert property (backoff |-> bus_request_out)
        else $error("backoff without bus request");
    a_false_strap: assert property (false_ready |-> !backoff)
        else $error("false ready while backoff used");
    a_forced_irq: assert property (false_ready |-> ##[1:3] deadlock_error_interrupt)
        else $error("no interrupt after forced termination");
    a_retry_cause: assert property ($rose(pci_tgt_retry) |-> $past(pci_tgt_access, 3))
        else $error("retry without target access");
    c_cfg: cover property (pci_req.valid && pci_req.space == DMB_SP_CFG);
    c_backoff: cover property (backoff);
    c_false: cover property (false_ready);
    c_slverr: cover property (pslverr);
endmodule
bind dmb_bridge dmb_bridge_properties i_chk (.clk, .sys_rst, .psel, .penable, .pready,
    .pslverr, .lcl_req, .pci_req, .pci_tgt_access, .pci_tgt_retry, .bus_request_out,
    .backoff, .false_ready, .deadlock_error_interrupt);
`default_nettype wire

//--- verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import dmb_pkg::*;
    logic         clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic         cpu_has_backoff = 1'b0, want_inbound = 1'b0, want_access = 1'b0;
    logic [7:0]   paddr = 8'h00;
    logic [31:0]  pwdata = 32'h0, prdata;
    logic [3:0]   wfifo_count = 4'h0;
    logic         pready, pslverr, pci_clk, pci_inbound_req, pci_tgt_access, af_n;
    logic         pci_tgt_retry, bus_request_out, backoff, false_ready, dl_irq, lock, keep;
    dmb_lcl_req_s lcl_req = '0;
    dmb_pci_req_s pci_req;
    int           fail_count = 0, num_checks = 0, cycles = 0;

    always #5 clk = ~clk;
    dmb_pci_agent i_agent (.want_inbound, .want_access, .pci_clk, .pci_inbound_req,
        .pci_tgt_access);
    dmb_bridge i_dut (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .lcl_req, .pci_req, .pci_clk, .pci_inbound_req, .pci_tgt_access,
        .cpu_has_backoff, .wfifo_count, .pci_tgt_retry, .bus_request_out, .backoff,
        .false_ready, .deadlock_error_interrupt(dl_irq), .pci_lock_en(lock),
        .rd_full_keep_bus(keep), .write_fifo_almost_full_flag_n(af_n));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Waiting an edge first keeps psel from being assigned twice in one step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // No fixed wait: only the hang guard ends a missing answer
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        check(q, x);
    endtask
    task automatic lcl(input logic io, input logic [31:0] a, input logic v,
                       input dmb_space_e s, input logic [31:0] x);
        @(posedge clk);
        lcl_req <= '{1'b1, io, a};
        repeat (2) @(posedge clk);
        check(32'(pci_req.valid), 32'(v));
        if (v)
        begin
            check(32'(pci_req.space), 32'(s));
            check(pci_req.addr, x);
        end
        lcl_req <= '0;
    endtask
    task automatic dl_run(input logic [3:0] t, output int n);
        wr(DMB_OFF_DLCTL, {27'h0, 1'b1, t});
        n = 0;
        lcl_req <= '{1'b1, 1'b0, 32'h4000_0000};
        do
        begin
            @(posedge clk);
            n++;
        end
        while (bus_request_out !== 1'b1);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs;
        logic [31:0] q;
        logic        e;
        rdc(DMB_OFF_REMAP, 32'h0);
        rdc(DMB_OFF_CFGADR, 32'h0);
        wr(DMB_OFF_MBASE, 32'hffff_ffff);
        rdc(DMB_OFF_MBASE, 32'hffff_0000);
        wr(DMB_OFF_IOBASE, 32'hffff_ffff);
        rdc(DMB_OFF_IOBASE, 32'hffff_0000);
        wr(DMB_OFF_REMAP, 32'hffff_ff1f);
        rdc(DMB_OFF_REMAP, 32'hffff_001f);
        check(32'(lock), 32'h1);
        check(32'(keep), 32'h1);
        wr(DMB_OFF_CFGADR, 32'h0001_0a0d);
        rdc(DMB_OFF_CFGADR, 32'h0001_0a0d);
        wfifo_count <= 4'h3;
        wr(DMB_OFF_REMAP, 32'h0);
        repeat (2) @(posedge clk);
        check(32'(af_n), 32'h0);
        check(32'(lock), 32'h0);
        check(32'(keep), 32'h0);
        wfifo_count <= 4'h0;
        apb(1'b0, 8'h80, 32'h0, q, e);
        check(q, 32'h0);
        check(32'(e), 32'h1);
        check(32'(af_n), 32'h1);
    endtask
    task automatic t_decode;
        wr(DMB_OFF_RANGE, 32'hc000_0000);
        wr(DMB_OFF_MBASE, 32'h4000_0000);
        wr(DMB_OFF_IOBASE, 32'h8000_0000);
        wr(DMB_OFF_CFGADR, 32'h0);
        lcl(1'b0, 32'h4000_1234, 1'b0, DMB_SP_MEM, 32'h0);
        wr(DMB_OFF_REMAP, 32'h8000_0001);
        lcl(1'b0, 32'h4000_1234, 1'b1, DMB_SP_MEM, 32'h8000_1234);
        lcl(1'b0, 32'hc000_1234, 1'b0, DMB_SP_MEM, 32'h0);
        lcl(1'b1, 32'h8000_0010, 1'b0, DMB_SP_IO, 32'h0);
        wr(DMB_OFF_RANGE, 32'h4000_0000);
        lcl(1'b0, 32'hc000_1234, 1'b1, DMB_SP_MEM, 32'h8000_1234);
        wr(DMB_OFF_RANGE, 32'hc000_0000);
        wr(DMB_OFF_REMAP, 32'h8000_0003);
        lcl(1'b1, 32'h8000_0010, 1'b1, DMB_SP_IO, 32'h8000_0010);
        lcl(1'b1, 32'h4000_0010, 1'b0, DMB_SP_IO, 32'h0);
        wr(DMB_OFF_CFGADR, 32'h8001_0a0d);
        lcl(1'b1, 32'h8000_0010, 1'b1, DMB_SP_CFG, 32'h0001_0a0d);
        wr(DMB_OFF_CFGADR, 32'h0);
    endtask
    task automatic t_deadlock;
        int n1;
        int n2;
        int k;
        want_inbound <= 1'b1;
        cpu_has_backoff <= 1'b1;
        wr(DMB_OFF_DLCTL, 32'h0000_0003);
        lcl_req <= '{1'b1, 1'b0, 32'h4000_0000};
        repeat (60) @(posedge clk);
        check(32'(bus_request_out), 32'h0);
        lcl_req <= '0;
        dl_run(4'h1, n1);
        @(posedge clk);
        check(32'(backoff), 32'h1);
        lcl_req <= '0;
        dl_run(4'hf, n2);
        check(n2 - n1, 32'd14);
        lcl_req <= '0;
        cpu_has_backoff <= 1'b0;
        repeat (5) @(posedge clk);
        check(32'(bus_request_out), 32'h0);
        dl_run(4'h2, n1);
        k = 0;
        repeat (6)
        begin
            @(posedge clk);
            if (false_ready === 1'b1) k++;
        end
        check(32'(backoff), 32'h0);
        check(32'(k > 0), 32'h1);
        lcl_req <= '0;
        want_inbound <= 1'b0;
        // Inbound flag clears only after a full trip through the PCI clock
        repeat (40) @(posedge clk);
        check(32'(dl_irq), 32'h1);
        rdc(DMB_OFF_STAT, 32'h0000_0001);
        wr(DMB_OFF_STAT, 32'h0000_0001);
        repeat (3) @(posedge clk);
        check(32'(dl_irq), 32'h0);
    endtask
    task automatic t_init;
        want_access <= 1'b1;
        repeat (30) @(posedge clk);
        check(32'(pci_tgt_retry), 32'h1);
        wr(DMB_OFF_INIT, 32'h8000_0000);
        repeat (5) @(posedge clk);
        check(32'(pci_tgt_retry), 32'h0);
        want_access <= 1'b0;
    endtask

    // Hang guard: whole run needs a few hundred cycles
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            fail_count++;
            complete_run();
        end
    end
    initial
    begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        t_regs();
        t_decode();
        t_deadlock();
        t_init();
        complete_run();
    end
endmodule
`default_nettype wire
